/* File: test/aabie_core_chk.sv */
// port assertions for the execution core
module aabie_core_chk #(
    parameter int PC_W = 21
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [15:0] i_instr,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic [aabie_pkg::DM_AW-1:0] o_dm_addr,
    input wire logic o_dm_re,
    input wire logic o_dm_we,
    input wire logic [7:0] o_dm_wdata,
    input wire logic [7:0] i_dm_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    sequence quiet_s;
        !o_dm_re && !o_dm_we;
    endsequence
    sequence addr_held_s;
        $stable(o_dm_addr) [*2];
    endsequence

    read_pulse_a: assert property (o_dm_re |=> !o_dm_re)
        else $error("file read longer than one clock");
    write_pulse_a: assert property (o_dm_we |=> !o_dm_we)
        else $error("file write longer than one clock");
    read_then_write_a: assert property (o_dm_we |-> $past(o_dm_re, 2))
        else $error("file write without read two clocks before");
    addr_hold_a: assert property (o_dm_re |=> addr_held_s)
        else $error("file address moved inside instruction");
    fetch_step_a: assert property ($rose(o_dm_re) |-> o_pc == $past(o_pc) + PC_W'(2))
        else $error("pc did not step by two at decode");
    pc_settle_a: assert property ($changed(o_pc) |=> $stable(o_pc) [*2])
        else $error("pc changed twice within three clocks");
    branch_idle_a: assert property (($changed(o_pc) && o_pc != $past(o_pc) + PC_W'(2))
        |-> quiet_s [*4])
        else $error("memory activity in idle cycle after taken branch");
    clear_bit_a: assert property ((o_dm_we && $past(i_instr[15:12], 3) == aabie_pkg::OPC_BCLR)
        |-> o_dm_wdata == ($past(i_dm_rdata, 2) & ~(8'h01 << $past(i_instr[11:9], 3))))
        else $error("clear bit wrote wrong value");
    dest_acc_a: assert property ((o_dm_re && $past(i_instr[15:9]) == {aabie_pkg::OPC_ADDC,
        aabie_pkg::DEST_ACC}) |-> ##2 !o_dm_we)
        else $error("file written with accumulator destination");
endmodule

bind aabie_core aabie_core_chk #(.PC_W(PC_W)) i_aabie_core_chk (.i_mclk, .i_reset, .i_instr,
    .o_pc, .o_dm_addr, .o_dm_re, .o_dm_we, .o_dm_wdata, .i_dm_rdata);

/* File: test/aabie_mem_model.sv */
// program and data memory facing the execution core
module aabie_mem_model #(
    parameter int PC_W = 21
) (
    input wire logic i_mclk,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic [aabie_pkg::DM_AW-1:0] i_addr,
    input wire logic i_re,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [15:0] o_instr,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] prog [256];
    logic [7:0] data [4096];

    assign o_instr = prog[i_pc[8:1]];
    // outside a read the lines show garbage so a late sample cannot pass
    assign o_rdata = i_re ? data[i_addr] : ~data[i_addr];

    always @(posedge i_mclk)
    begin
        if (i_we)
        begin
            data[i_addr] <= i_wdata;
        end
    end
endmodule

/* File: test/test_add_and_branch_instr_exec.sv */
// testbench for the add/and/branch execution slice
module test_add_and_branch_instr_exec;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, dm_re, dm_we;
    logic [31:0] hrdata, rd;
    logic [15:0] instr;
    logic [20:0] pc;
    logic [11:0] dm_addr;
    logic [7:0] dm_wdata, dm_rdata;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;

    always #50 i_mclk = ~i_mclk;

    aabie_core i_aabie_core (.i_mclk(i_mclk), .i_reset(i_reset), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_instr(instr), .o_pc(pc), .o_dm_addr(dm_addr), .o_dm_re(dm_re),
        .o_dm_we(dm_we), .o_dm_wdata(dm_wdata), .i_dm_rdata(dm_rdata));
    aabie_mem_model i_aabie_mem_model (.i_mclk(i_mclk), .i_pc(pc), .i_addr(dm_addr),
        .i_re(dm_re), .i_we(dm_we), .i_wdata(dm_wdata), .o_instr(instr), .o_rdata(dm_rdata));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // single ahb-lite transfer; hready is waited on, never assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge i_mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        // the slave never answers anything but okay
        chk({31'h0, hresp}, 32'h0);
    endtask

    function automatic logic [31:0] mem(input logic [11:0] a);
        return {24'h0, i_aabie_mem_model.data[a]};
    endfunction

    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            test_done();
        end
    end

    initial
    begin
        for (int k = 0; k < 256; k++) i_aabie_mem_model.prog[k] = 16'hffff;
        for (int k = 0; k < 4096; k++) i_aabie_mem_model.data[k] = 8'h00;
        i_aabie_mem_model.prog[0] = 16'h2060;
        i_aabie_mem_model.prog[1] = 16'h0b5f;
        i_aabie_mem_model.prog[2] = 16'h1730;
        i_aabie_mem_model.prog[3] = 16'h9e10;
        i_aabie_mem_model.prog[4] = 16'h2220;
        i_aabie_mem_model.prog[5] = 16'he205;
        i_aabie_mem_model.prog[6] = 16'he603;
        i_aabie_mem_model.prog[10] = 16'he57f;
        i_aabie_mem_model.prog[11] = 16'he37f;
        i_aabie_mem_model.prog[139] = 16'he77f;
        i_aabie_mem_model.prog[140] = 16'he180;
        i_aabie_mem_model.prog[13] = 16'he1ff;
        i_aabie_mem_model.data[12'hf60] = 8'h02;
        i_aabie_mem_model.data[12'h330] = 8'hc2;
        i_aabie_mem_model.data[12'h210] = 8'hc7;
        i_aabie_mem_model.data[12'h220] = 8'h7f;
        // second program: and-file into acc from the access bank, then a self loop
        i_aabie_mem_model.prog[32] = 16'h1410;
        i_aabie_mem_model.prog[33] = 16'he7ff;
        i_aabie_mem_model.data[12'h010] = 8'h3c;
        repeat (5) @(posedge i_mclk);
        i_reset <= 1'b0;
        rd_chk(aabie_pkg::OFS_ACC, 32'h0);
        rd_chk(aabie_pkg::OFS_FLAGS, 32'h0);
        rd_chk(8'h40, 32'h0);
        $display("reset values test done");
        bus(1'b1, aabie_pkg::OFS_FLAGS, 32'h01);
        bus(1'b1, aabie_pkg::OFS_ACC, 32'h4d);
        bus(1'b1, aabie_pkg::OFS_BANK, 32'h3);
        bus(1'b1, aabie_pkg::OFS_INDEX, 32'h200);
        bus(1'b1, aabie_pkg::OFS_CTRL, 32'h3);
        for (int k = 0; k < 300 && rd !== 32'h1a; k++) bus(1'b0, aabie_pkg::OFS_PC, 32'h0);
        bus(1'b1, aabie_pkg::OFS_CTRL, 32'h2);
        repeat (12) @(posedge i_mclk);
        rd_chk(aabie_pkg::OFS_PC, 32'h1a);
        rd_chk(aabie_pkg::OFS_ACC, 32'h50);
        rd_chk(aabie_pkg::OFS_FLAGS, 32'h18);
        chk(mem(12'hf60), 32'h02);
        chk(mem(12'h330), 32'h40);
        chk(mem(12'h210), 32'h47);
        chk(mem(12'h220), 32'hcf);
        $display("program test done");
        // extended set off: a low file field must use the access bank, not the index
        bus(1'b1, aabie_pkg::OFS_PC, 32'h40);
        bus(1'b1, aabie_pkg::OFS_CTRL, 32'h1);
        for (int k = 0; k < 300 && rd !== 32'h42; k++) bus(1'b0, aabie_pkg::OFS_PC, 32'h0);
        bus(1'b1, aabie_pkg::OFS_CTRL, 32'h0);
        repeat (12) @(posedge i_mclk);
        rd_chk(aabie_pkg::OFS_PC, 32'h42);
        rd_chk(aabie_pkg::OFS_ACC, 32'h10);
        rd_chk(aabie_pkg::OFS_FLAGS, 32'h08);
        chk(mem(12'h010), 32'h3c);
        $display("access bank test done");
        test_done();
    end
endmodule

/* File: verilog/aabie_alu.sv */
// arithmetic and logic unit of the execution slice
module aabie_alu (
    aabie_alu_if.alu bus
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb
    begin
        sum = {1'b0, bus.acc} + {1'b0, bus.file} + {8'h00, bus.flags_in[aabie_pkg::FLAG_C]};
        low_sum = {1'b0, bus.acc[3:0]} + {1'b0, bus.file[3:0]}
            + {4'h0, bus.flags_in[aabie_pkg::FLAG_C]};
        bus.result = bus.file;
        bus.flags_out = bus.flags_in;
        case (bus.op)
            aabie_pkg::OP_ADDC:
            begin
                bus.result = sum[7:0];
                bus.flags_out[aabie_pkg::FLAG_C] = sum[8];
                bus.flags_out[aabie_pkg::FLAG_DIGIT] = low_sum[4];
                bus.flags_out[aabie_pkg::FLAG_OVFL] =
                    (bus.acc[7] == bus.file[7]) && (sum[7] != bus.acc[7]);
                bus.flags_out[aabie_pkg::FLAG_N] = sum[7];
                bus.flags_out[aabie_pkg::FLAG_Z] = (sum[7:0] == 8'h00);
            end
            aabie_pkg::OP_ANDL, aabie_pkg::OP_ANDF:
            begin
                // only N and Z move for the and forms
                if (bus.op == aabie_pkg::OP_ANDL)
                begin
                    bus.result = bus.acc & bus.lit;
                end
                else
                begin
                    bus.result = bus.acc & bus.file;
                end
                bus.flags_out[aabie_pkg::FLAG_N] = bus.result[7];
                bus.flags_out[aabie_pkg::FLAG_Z] = (bus.result == 8'h00);
            end
            aabie_pkg::OP_BCLR:
            begin
                bus.result = bus.file & ~(8'h01 << bus.bitpos);
            end
            default:
            begin
                bus.result = bus.file;
            end
        endcase
    end
endmodule

/* File: verilog/aabie_alu_if.sv */
// carrier between the execution core and its arithmetic unit
interface aabie_alu_if;
    aabie_pkg::aabie_op_t op;
    logic [7:0] acc;
    logic [7:0] file;
    logic [7:0] lit;
    logic [2:0] bitpos;
    logic [aabie_pkg::FLAG_W-1:0] flags_in;
    logic [7:0] result;
    logic [aabie_pkg::FLAG_W-1:0] flags_out;

    modport core (
        output op, acc, file, lit, bitpos, flags_in,
        input result, flags_out
    );

    modport alu (
        input op, acc, file, lit, bitpos, flags_in,
        output result, flags_out
    );
endinterface

/* File: verilog/aabie_core.sv */
// execution core: ahb-lite registers, four-phase sequencer, operand routing
module aabie_core #(
    parameter int PC_W = 21
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic [15:0] i_instr,
    output logic [PC_W-1:0] o_pc,
    output logic [aabie_pkg::DM_AW-1:0] o_dm_addr,
    output logic o_dm_re,
    output logic o_dm_we,
    output logic [7:0] o_dm_wdata,
    input wire logic [7:0] i_dm_rdata
);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    function automatic aabie_pkg::aabie_op_t decode(input logic [15:0] w);
        aabie_pkg::aabie_op_t op;
        op = aabie_pkg::OP_NOP;
        if (w[15:10] == aabie_pkg::OPC_ADDC)
            op = aabie_pkg::OP_ADDC;
        else if (w[15:8] == aabie_pkg::OPC_ANDL)
            op = aabie_pkg::OP_ANDL;
        else if (w[15:10] == aabie_pkg::OPC_ANDF)
            op = aabie_pkg::OP_ANDF;
        else if (w[15:12] == aabie_pkg::OPC_BCLR)
            op = aabie_pkg::OP_BCLR;
        else if (w[15:8] == aabie_pkg::OPC_BR_CS)
            op = aabie_pkg::OP_BR_CS;
        else if (w[15:8] == aabie_pkg::OPC_BR_NS)
            op = aabie_pkg::OP_BR_NS;
        else if (w[15:8] == aabie_pkg::OPC_BR_CC)
            op = aabie_pkg::OP_BR_CC;
        else if (w[15:8] == aabie_pkg::OPC_BR_NC)
            op = aabie_pkg::OP_BR_NC;
        else if (w[15:8] == aabie_pkg::OPC_BR_OC)
            op = aabie_pkg::OP_BR_OC;
        else if (w[15:8] == aabie_pkg::OPC_BR_ZC)
            op = aabie_pkg::OP_BR_ZC;
        return op;
    endfunction

    // anything outside this slice decodes as an idle cycle
    function automatic logic reads_file(input aabie_pkg::aabie_op_t op);
        return (op == aabie_pkg::OP_ADDC) || (op == aabie_pkg::OP_ANDF)
            || (op == aabie_pkg::OP_BCLR);
    endfunction

    function automatic logic writes_file(input aabie_pkg::aabie_op_t op, input logic d);
        return (((op == aabie_pkg::OP_ADDC) || (op == aabie_pkg::OP_ANDF))
            && (d == aabie_pkg::DEST_FILE)) || (op == aabie_pkg::OP_BCLR);
    endfunction

    function automatic logic writes_acc(input aabie_pkg::aabie_op_t op, input logic d);
        return (((op == aabie_pkg::OP_ADDC) || (op == aabie_pkg::OP_ANDF))
            && (d == aabie_pkg::DEST_ACC)) || (op == aabie_pkg::OP_ANDL);
    endfunction

    function automatic logic branch_taken(input aabie_pkg::aabie_op_t op,
                                          input logic [aabie_pkg::FLAG_W-1:0] fl);
        logic t;
        t = 1'b0;
        case (op)
            aabie_pkg::OP_BR_CS: t = fl[aabie_pkg::FLAG_C];
            aabie_pkg::OP_BR_NS: t = fl[aabie_pkg::FLAG_N];
            aabie_pkg::OP_BR_CC: t = !fl[aabie_pkg::FLAG_C];
            aabie_pkg::OP_BR_NC: t = !fl[aabie_pkg::FLAG_N];
            aabie_pkg::OP_BR_OC: t = !fl[aabie_pkg::FLAG_OVFL];
            aabie_pkg::OP_BR_ZC: t = !fl[aabie_pkg::FLAG_Z];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic [aabie_pkg::DM_AW-1:0] file_addr(
        input logic a, input logic [7:0] f, input logic ext,
        input logic [aabie_pkg::BANK_W-1:0] bank, input logic [aabie_pkg::DM_AW-1:0] base);
        logic [aabie_pkg::DM_AW-1:0] r;
        if (a)
            r = {bank, f};
        else if (f <= aabie_pkg::ACCESS_LIMIT && ext)
            r = base + {4'h0, f};
        else if (f <= aabie_pkg::ACCESS_LIMIT)
            r = {aabie_pkg::ACCESS_LO_BANK, f};
        else
            r = {aabie_pkg::ACCESS_HI_BANK, f};
        return r;
    endfunction

    // ****************************************************************
    // bus slave
    // ****************************************************************
    logic run_q, run_d, ext_q, ext_d;
    logic [aabie_pkg::BANK_W-1:0] bank_q, bank_d;
    logic [aabie_pkg::DM_AW-1:0] index_q, index_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_ofs_q, wr_ofs_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic sw_acc_we, sw_flags_we, sw_pc_we;

    // execution state, declared here for the read mux
    aabie_pkg::aabie_phase_t phase_q, phase_d;
    aabie_pkg::aabie_op_t op_q, op_d;
    logic flush_q, flush_d, taken_q, taken_d;
    logic [15:0] instr_q, instr_d;
    logic [7:0] acc_q, acc_d, operand_q, operand_d, result_q, result_d;
    logic [aabie_pkg::FLAG_W-1:0] flags_q, flags_d, fnew_q, fnew_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [aabie_pkg::DM_AW-1:0] dm_addr_q, dm_addr_d;
    logic dm_re_q, dm_re_d, dm_we_q, dm_we_d;

    always_comb
    begin
        run_d = run_q;
        ext_d = ext_q;
        bank_d = bank_q;
        index_d = index_q;
        hrdata_d = hrdata_q;
        sw_acc_we = 1'b0;
        sw_flags_we = 1'b0;
        sw_pc_we = 1'b0;
        // write data arrives one cycle after its address phase
        if (wr_pend_q)
        begin
            case (wr_ofs_q)
                aabie_pkg::OFS_CTRL:
                begin
                    run_d = i_hwdata[aabie_pkg::CTRL_RUN_BIT];
                    ext_d = i_hwdata[aabie_pkg::CTRL_EXT_BIT];
                end
                aabie_pkg::OFS_BANK: bank_d = i_hwdata[aabie_pkg::BANK_W-1:0];
                aabie_pkg::OFS_INDEX: index_d = i_hwdata[aabie_pkg::DM_AW-1:0];
                aabie_pkg::OFS_ACC: sw_acc_we = 1'b1;
                aabie_pkg::OFS_FLAGS: sw_flags_we = 1'b1;
                aabie_pkg::OFS_PC: sw_pc_we = 1'b1;
                default: sw_acc_we = 1'b0;
            endcase
        end
        wr_pend_d = i_hsel && i_htrans[1] && i_hready && i_hwrite;
        wr_ofs_d = i_haddr[7:0];
        if (i_hsel && i_htrans[1] && i_hready && !i_hwrite)
        begin
            case (i_haddr[7:0])
                aabie_pkg::OFS_CTRL: hrdata_d = {30'h0, ext_q, run_q};
                aabie_pkg::OFS_BANK: hrdata_d = {28'h0, bank_q};
                aabie_pkg::OFS_ACC: hrdata_d = {24'h0, acc_q};
                aabie_pkg::OFS_FLAGS: hrdata_d = {27'h0, flags_q};
                aabie_pkg::OFS_PC: hrdata_d = {{(32 - PC_W){1'b0}}, pc_q};
                aabie_pkg::OFS_INDEX: hrdata_d = {20'h0, index_q};
                aabie_pkg::OFS_STATE: hrdata_d = {24'h0, taken_q, flush_q, op_q, phase_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            run_q <= aabie_pkg::CTRL_RUN_RST;
            ext_q <= aabie_pkg::CTRL_EXT_RST;
            bank_q <= aabie_pkg::BANK_RST;
            index_q <= aabie_pkg::INDEX_RST;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            run_q <= run_d;
            ext_q <= ext_d;
            bank_q <= bank_d;
            index_q <= index_d;
            wr_pend_q <= wr_pend_d;
            wr_ofs_q <= wr_ofs_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_q;

    // ****************************************************************
    // arithmetic unit
    // ****************************************************************
    aabie_alu_if alu_bus ();

    assign alu_bus.op = op_q;
    assign alu_bus.acc = acc_q;
    assign alu_bus.file = operand_q;
    assign alu_bus.lit = instr_q[7:0];
    assign alu_bus.bitpos = instr_q[11:9];
    assign alu_bus.flags_in = flags_q;

    aabie_alu u_alu (
        .bus(alu_bus)
    );

    // ****************************************************************
    // four-phase sequencer
    // ****************************************************************
    always_comb
    begin
        phase_d = phase_q;
        op_d = op_q;
        flush_d = flush_q;
        taken_d = taken_q;
        instr_d = instr_q;
        acc_d = acc_q;
        operand_d = operand_q;
        result_d = result_q;
        flags_d = flags_q;
        fnew_d = fnew_q;
        pc_d = pc_q;
        dm_addr_d = dm_addr_q;
        dm_re_d = dm_re_q;
        dm_we_d = dm_we_q;
        // software writes first so a same-cycle hardware update overrides them
        if (sw_acc_we)
            acc_d = i_hwdata[7:0];
        if (sw_flags_we)
            flags_d = i_hwdata[aabie_pkg::FLAG_W-1:0];
        if (sw_pc_we)
            pc_d = {i_hwdata[PC_W-1:1], 1'b0};
        case (phase_q)
            aabie_pkg::PH_DECODE:
            begin
                // a cleared run bit parks the sequencer between instructions only
                if (run_q)
                begin
                    phase_d = aabie_pkg::PH_READ;
                    if (flush_q)
                    begin
                        flush_d = 1'b0;
                        op_d = aabie_pkg::OP_NOP;
                    end
                    else
                    begin
                        instr_d = i_instr;
                        op_d = decode(i_instr);
                        pc_d = pc_q + PC_W'(aabie_pkg::PC_STEP);
                        dm_addr_d = file_addr(i_instr[8], i_instr[7:0], ext_q, bank_q, index_q);
                        dm_re_d = reads_file(decode(i_instr));
                    end
                end
            end
            aabie_pkg::PH_READ:
            begin
                if (dm_re_q)
                    operand_d = i_dm_rdata;
                dm_re_d = 1'b0;
                phase_d = aabie_pkg::PH_PROCESS;
            end
            aabie_pkg::PH_PROCESS:
            begin
                result_d = alu_bus.result;
                fnew_d = alu_bus.flags_out;
                dm_we_d = writes_file(op_q, instr_q[9]);
                phase_d = aabie_pkg::PH_WRITE;
            end
            aabie_pkg::PH_WRITE:
            begin
                dm_we_d = 1'b0;
                flags_d = fnew_q;
                if (writes_acc(op_q, instr_q[9]))
                    acc_d = result_q;
                taken_d = branch_taken(op_q, flags_q);
                if (branch_taken(op_q, flags_q))
                begin
                    // pc already points past the branch
                    pc_d = pc_q + {{(PC_W - 9){instr_q[7]}}, instr_q[7:0], 1'b0};
                    flush_d = 1'b1;
                end
                phase_d = aabie_pkg::PH_DECODE;
            end
            default:
            begin
                phase_d = aabie_pkg::PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            phase_q <= aabie_pkg::PH_DECODE;
            op_q <= aabie_pkg::OP_NOP;
            flush_q <= 1'b0;
            taken_q <= 1'b0;
            instr_q <= 16'h0000;
            acc_q <= aabie_pkg::ACC_RST;
            operand_q <= 8'h00;
            result_q <= 8'h00;
            flags_q <= aabie_pkg::FLAGS_RST;
            fnew_q <= aabie_pkg::FLAGS_RST;
            pc_q <= '0;
            dm_addr_q <= '0;
            dm_re_q <= 1'b0;
            dm_we_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            op_q <= op_d;
            flush_q <= flush_d;
            taken_q <= taken_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            operand_q <= operand_d;
            result_q <= result_d;
            flags_q <= flags_d;
            fnew_q <= fnew_d;
            pc_q <= pc_d;
            dm_addr_q <= dm_addr_d;
            dm_re_q <= dm_re_d;
            dm_we_q <= dm_we_d;
        end
    end

    assign o_pc = pc_q;
    assign o_dm_addr = dm_addr_q;
    assign o_dm_re = dm_re_q;
    assign o_dm_we = dm_we_q;
    assign o_dm_wdata = result_q;

endmodule

/* File: verilog/aabie_pkg.sv */
// constants, types and encodings for the add/and/branch execution slice
//
// What this block does
// - add-with-carry-to-file sums acc, file and carry; sets all five flags; one cycle
// - destination bit 0 writes acc, 1 writes file back; 1 is the default
// - access bit 0 selects access bank; 1 lets bank select register choose bank
// - access bit 0 with extended set on: file field up to 95 is index-relative
// - and-immediate ands acc with low opcode byte into acc; flags N, Z only
// - and-file ands acc with file, routed by destination bit; N, Z; one cycle
// - clear-file-bit clears bit 0..7 of file register; flags untouched; one cycle
// - taken branch loads pc with incremented pc plus twice signed 8-bit offset
// - branch: one cycle not taken, two when taken with idle second; flags untouched
// - branch-on-carry-set branches only when carry is one
// - branch-on-negative-set branches only when negative is one
// - branch-on-carry-clear branches only when carry is zero
// - branch-on-negative-clear (1110 0111) branches only when negative is zero
// - branch-on-overflow-clear (1110 0101) branches only when overflow is zero
// - branch-on-zero-clear branches only when zero is zero
// - access bit 1: bank select register gives upper address bits above 8-bit field
package aabie_pkg;

    // ****************************************************************
    // register map (byte addresses on the bus)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_PC = 8'h10;
    localparam logic [7:0] OFS_INDEX = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;

    // ****************************************************************
    // status flag positions
    // ****************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVFL = 3;
    localparam int FLAG_N = 4;
    localparam int FLAG_W = 5;

    // ****************************************************************
    // data memory addressing
    // ****************************************************************
    localparam int BANK_W = 4;
    localparam int DM_AW = 12;
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ****************************************************************
    // opcode patterns
    // ****************************************************************
    localparam logic [5:0] OPC_ADDC = 6'h08;
    localparam logic [7:0] OPC_ANDL = 8'h0b;
    localparam logic [5:0] OPC_ANDF = 6'h05;
    localparam logic [3:0] OPC_BCLR = 4'h9;
    localparam logic [7:0] OPC_BR_CS = 8'he2;
    localparam logic [7:0] OPC_BR_NS = 8'he6;
    localparam logic [7:0] OPC_BR_CC = 8'he3;
    localparam logic [7:0] OPC_BR_NC = 8'he7;
    localparam logic [7:0] OPC_BR_OC = 8'he5;
    localparam logic [7:0] OPC_BR_ZC = 8'he1;

    // ****************************************************************
    // reset values and counts
    // ****************************************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
    localparam logic [DM_AW-1:0] INDEX_RST = 12'h000;
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam logic CTRL_EXT_RST = 1'b0;
    localparam int PC_STEP = 2;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADDC = 4'h1,
        OP_ANDL = 4'h2,
        OP_ANDF = 4'h3,
        OP_BCLR = 4'h4,
        OP_BR_CS = 4'h5,
        OP_BR_NS = 4'h6,
        OP_BR_CC = 4'h7,
        OP_BR_NC = 4'h8,
        OP_BR_OC = 4'h9,
        OP_BR_ZC = 4'ha
    } aabie_op_t;

    // gray order along q1 -> q2 -> q3 -> q4
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE = 2'b10
    } aabie_phase_t;

endpackage
